// >>> include/pmp_defines.svh
// Purpose: Offsets, field positions and reset values of the parallel port
// Assumes: Included by the parallel port package users
// Notes: Byte offsets on the register bus, one word per register
`ifndef PMP_DEFINES_SVH
`define PMP_DEFINES_SVH

`define OFF_CTL 8'h00
`define OFF_MODE 8'h04
`define OFF_ADDR 8'h08
`define OFF_DATA 8'h0c
`define OFF_OBUF 8'h10
`define OFF_IBUF 8'h14
`define OFF_STAT 8'h18
`define OFF_NONE 8'hff

`define C_EN 15
`define C_IDL 13
`define C_MUX 12:11
`define C_BEEN 10
`define C_WREN 9
`define C_RDEN 8
`define C_CSF 7:6
`define C_ALP 5
`define C_CSP 3
`define C_BEP 2
`define C_WRITE_STROBE_POLARITY 1
`define C_READ_STROBE_POLARITY 0

`define M_INTERRUPT_MODE_FIELD 14:13
`define M_INCREMENT_MODE_FIELD 12:11
`define M_W16 10
`define M_MODE 9:8
`define M_WB 7:6
`define M_WM 5:2
`define M_WE 1:0

`define A_CS 14
`define A_STEP 10:0

`define CTL_RST 16'h0000
`define CTL_WMASK 16'hbfef
`define MODE_RST 15'h0000
`define ADDR_RST 16'h0000
`define OBE_RST 4'hf

`endif

// >>> include/pmp_pkg.sv
// Purpose: Types shared by the parallel port
// Assumes: Nothing beyond the defines header
// Notes: Mode codes follow the mode register encodings
package pmp_pkg;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ALO = 3'b001,
        PH_AHI = 3'b010,
        PH_SETUP = 3'b011,
        PH_STROBE = 3'b100,
        PH_HOLD = 3'b101
    } phase_t;

    typedef enum logic [1:0] {
        PM_LEGACY = 2'b00,
        PM_ENHANCED = 2'b01,
        PM_MASTER2 = 2'b10,
        PM_MASTER1 = 2'b11
    } port_mode_t;

    typedef enum logic [1:0] {
        MX_NONE = 2'b00,
        MX_LOW = 2'b01,
        MX_FULL = 2'b10
    } mux_t;

    typedef struct packed {
        logic [7:0] pd_out;
        logic pd_oe;
        logic [10:0] pa_out;
        logic pa_oe;
        logic cs_out;
        logic cs_oe;
        logic rd_out;
        logic rd_oe;
        logic wr_out;
        logic wr_oe;
        logic be_out;
        logic be_oe;
    } pins_t;

endpackage

// >>> core/parallel_master_slave_port.sv
// Purpose: 8-bit parallel master/slave port behind an AHB-Lite slave
// Assumes: One clock cycle per instruction cycle; pins synchronised here
// Notes: All state lives in one struct registered once per clock
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "pmp_defines.svh"

module parallel_master_slave_port
    import pmp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic cpu_idle,
    output logic cpu_stall,
    output logic port_event,
    input wire logic [7:0] port_data_in,
    output logic [7:0] port_data_out,
    output logic port_data_oe,
    input wire logic [1:0] port_address_in,
    output logic [10:0] port_address_out,
    output logic port_address_oe,
    input wire logic chip_select_in,
    output logic chip_select_out,
    output logic chip_select_oe,
    input wire logic read_strobe_in,
    output logic read_strobe_out,
    output logic read_strobe_oe,
    input wire logic write_strobe_in,
    output logic write_strobe_out,
    output logic write_strobe_oe,
    output logic byte_enable_pin,
    output logic byte_enable_oe
);

    typedef struct packed {
        logic [15:0] ctl;
        logic [14:0] mode;
        logic [15:0] addr;
        logic [15:0] dout;
        logic [15:0] din;
        phase_t phase;
        logic [3:0] cnt;
        logic hi;
        logic rd_op;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] aoff;
        logic [31:0] hrdata;
        logic evt;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] flt;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        logic [1:0] sact;
        logic [31:0] obuf;
        logic [31:0] ibuf;
        logic [3:0] ibf;
        logic [3:0] obe;
        logic [1:0] sptr;
        pins_t pins;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic xfer_end;

    function automatic logic [1:0] slave_idx(state_t s);
        if (port_mode_t'(s.mode[`M_MODE]) == PM_ENHANCED)
            return s.flt[1:0];
        else if (s.mode[`M_INCREMENT_MODE_FIELD] == 2'b11)
            return s.sptr;
        else
            return 2'b00;
    endfunction

    function automatic pins_t pins_of(state_t s);
        pins_t p;
        logic stb;
        logic act;
        logic [1:0] ix;
        p = '0;
        stb = (s.phase == PH_STROBE);
        act = (s.phase != PH_IDLE);
        ix = slave_idx(s);
        if (s.ctl[`C_EN] && s.mode[9])
        begin
            if (s.phase == PH_ALO)
            begin
                p.pd_out = s.addr[7:0];
                p.pd_oe = 1'b1;
            end
            else if (s.phase == PH_AHI)
            begin
                p.pd_out = s.addr[15:8];
                p.pd_oe = 1'b1;
            end
            else if (act && !s.rd_op)
            begin
                p.pd_out = s.hi ? s.dout[15:8] : s.dout[7:0];
                p.pd_oe = 1'b1;
            end
            p.pa_out = s.addr[10:0];
            p.pa_oe = 1'b1;
            if (mux_t'(s.ctl[`C_MUX]) != MX_NONE)
            begin
                p.pa_out[0] = (s.phase == PH_ALO) ~^ s.ctl[`C_ALP];
                p.pa_out[1] = (s.phase == PH_AHI) ~^ s.ctl[`C_ALP];
            end
            if (s.ctl[`C_CSF] == 2'b10)
                p.cs_out = s.addr[`A_CS] ~^ s.ctl[`C_CSP];
            else
                p.cs_out = s.addr[`A_CS];
            p.cs_oe = 1'b1;
            p.be_out = (act && s.mode[`M_W16]) ~^ s.ctl[`C_BEP];
            p.be_oe = s.ctl[`C_BEEN];
            if (port_mode_t'(s.mode[`M_MODE]) == PM_MASTER1)
            begin
                p.rd_out = (act && s.rd_op) ~^ s.ctl[`C_READ_STROBE_POLARITY];
                p.wr_out = stb ~^ s.ctl[`C_WRITE_STROBE_POLARITY];
            end
            else
            begin
                p.rd_out = (stb && s.rd_op) ~^ s.ctl[`C_READ_STROBE_POLARITY];
                p.wr_out = (stb && !s.rd_op) ~^ s.ctl[`C_WRITE_STROBE_POLARITY];
            end
            p.rd_oe = s.ctl[`C_RDEN];
            p.wr_oe = s.ctl[`C_WREN];
        end
        else if (s.ctl[`C_EN] && s.sact[0])
        begin
            p.pd_out = s.obuf[ix*8 +: 8];
            p.pd_oe = 1'b1;
        end
        return p;
    endfunction

    always_comb
    begin
        logic take;
        logic master;
        logic halt;
        logic go;
        logic go_rd;
        logic bd;
        logic cs_a;
        logic wr_a;
        logic rd_a;
        logic [1:0] ix;
        phase_t ent_ph;
        logic [3:0] ent_cnt;
        st_next = st_reg;
        take = hsel && htrans[1] && hready;
        // mode field picks master or slave
        master = st_reg.mode[9];
        halt = st_reg.ctl[`C_IDL] && cpu_idle;
        go = 1'b0;
        go_rd = 1'b0;
        bd = 1'b0;
        xfer_end = 1'b0;
        cs_a = 1'b0;
        wr_a = 1'b0;
        rd_a = 1'b0;
        ix = slave_idx(st_reg);
        ent_ph = (st_reg.mode[`M_WM] == 4'h0) ? PH_STROBE : PH_SETUP;
        ent_cnt = (st_reg.mode[`M_WM] == 4'h0) ? 4'h0 : {2'b00, st_reg.mode[`M_WB]};
        st_next.evt = 1'b0;
        st_next.s1 = {chip_select_in, write_strobe_in, read_strobe_in, port_address_in};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.flt = (st_reg.s2 & st_reg.s3) | (st_reg.flt & (st_reg.s2 | st_reg.s3));
        st_next.d1 = port_data_in;
        st_next.d2 = st_reg.d1;
        st_next.d3 = st_reg.d2;
        st_next.wr_pend = take && hwrite;
        st_next.rd_pend = take && !hwrite;
        if (take)
            st_next.aoff = (haddr[31:8] == 24'h0) ? haddr[7:0] : `OFF_NONE;
        if (st_reg.wr_pend)
        begin
            case (st_reg.aoff)
                `OFF_CTL: st_next.ctl = hwdata[15:0] & `CTL_WMASK;
                `OFF_MODE: st_next.mode = hwdata[14:0];
                `OFF_ADDR: st_next.addr = hwdata[15:0];
                `OFF_DATA:
                begin
                    go = 1'b1;
                    st_next.dout = hwdata[15:0];
                end
                `OFF_OBUF:
                begin
                    st_next.obuf = hwdata;
                    st_next.obe = 4'h0;
                end
                default: ;
            endcase
        end
        if (st_reg.rd_pend)
        begin
            case (st_reg.aoff)
                `OFF_CTL: st_next.hrdata = {16'h0000, st_reg.ctl};
                `OFF_MODE: st_next.hrdata = {16'h0000, st_reg.phase != PH_IDLE, st_reg.mode};
                `OFF_ADDR: st_next.hrdata = {16'h0000, st_reg.addr};
                `OFF_DATA:
                begin
                    st_next.hrdata = {16'h0000, st_reg.mode[`M_W16] ? st_reg.din[15:8] : 8'h00, st_reg.din[7:0]};
                    go = 1'b1;
                    go_rd = 1'b1;
                end
                `OFF_OBUF: st_next.hrdata = st_reg.obuf;
                `OFF_IBUF:
                begin
                    st_next.hrdata = st_reg.ibuf;
                    st_next.ibf = 4'h0;
                end
                `OFF_STAT: st_next.hrdata = {20'h00000, st_reg.ibf, 4'h0, st_reg.obe};
                default: st_next.hrdata = 32'h00000000;
            endcase
        end
        if (!st_reg.ctl[`C_EN] || !master)
            st_next.phase = PH_IDLE;
        else if (!halt)
        begin
            case (st_reg.phase)
                PH_IDLE:
                begin
                    if (go)
                    begin
                        st_next.hi = 1'b0;
                        st_next.rd_op = go_rd;
                        if (mux_t'(st_reg.ctl[`C_MUX]) != MX_NONE)
                        begin
                            st_next.phase = PH_ALO;
                            st_next.cnt = {2'b00, st_reg.mode[`M_WB]};
                        end
                        else
                        begin
                            st_next.phase = ent_ph;
                            st_next.cnt = ent_cnt;
                        end
                    end
                end
                PH_ALO:
                begin
                    if (st_reg.cnt != 4'h0)
                        st_next.cnt = st_reg.cnt - 4'h1;
                    else if (mux_t'(st_reg.ctl[`C_MUX]) == MX_FULL)
                    begin
                        st_next.phase = PH_AHI;
                        st_next.cnt = {2'b00, st_reg.mode[`M_WB]};
                    end
                    else
                    begin
                        st_next.phase = ent_ph;
                        st_next.cnt = ent_cnt;
                    end
                end
                PH_AHI:
                begin
                    if (st_reg.cnt != 4'h0)
                        st_next.cnt = st_reg.cnt - 4'h1;
                    else
                    begin
                        st_next.phase = ent_ph;
                        st_next.cnt = ent_cnt;
                    end
                end
                PH_SETUP:
                begin
                    if (st_reg.cnt != 4'h0)
                        st_next.cnt = st_reg.cnt - 4'h1;
                    else
                    begin
                        st_next.phase = PH_STROBE;
                        st_next.cnt = st_reg.mode[`M_WM];
                    end
                end
                PH_STROBE:
                begin
                    if (st_reg.cnt != 4'h0)
                        st_next.cnt = st_reg.cnt - 4'h1;
                    else
                    begin
                        if (st_reg.rd_op && st_reg.hi)
                            st_next.din[15:8] = st_reg.d3;
                        else if (st_reg.rd_op)
                            st_next.din[7:0] = st_reg.d3;
                        if (st_reg.mode[`M_WM] == 4'h0)
                            bd = 1'b1;
                        else
                        begin
                            st_next.phase = PH_HOLD;
                            st_next.cnt = {2'b00, st_reg.mode[`M_WE]};
                        end
                    end
                end
                PH_HOLD:
                begin
                    if (st_reg.cnt != 4'h0)
                        st_next.cnt = st_reg.cnt - 4'h1;
                    else
                        bd = 1'b1;
                end
                default: st_next.phase = PH_IDLE;
            endcase
        end
        if (bd && st_reg.mode[`M_W16] && !st_reg.hi)
        begin
            st_next.hi = 1'b1;
            st_next.phase = ent_ph;
            st_next.cnt = ent_cnt;
        end
        else if (bd)
        begin
            st_next.phase = PH_IDLE;
            xfer_end = 1'b1;
            if (st_reg.mode[`M_INCREMENT_MODE_FIELD] == 2'b01)
                st_next.addr[`A_STEP] = st_reg.addr[`A_STEP] + 11'h001;
            else if (st_reg.mode[`M_INCREMENT_MODE_FIELD] == 2'b10)
                st_next.addr[`A_STEP] = st_reg.addr[`A_STEP] - 11'h001;
            st_next.evt = (st_reg.mode[`M_INTERRUPT_MODE_FIELD] == 2'b01);
        end
        st_next.sact = 2'b00;
        if (st_reg.ctl[`C_EN] && !halt && !master)
        begin
            cs_a = (st_reg.flt[4] == st_reg.ctl[`C_CSP]);
            wr_a = (st_reg.flt[3] == st_reg.ctl[`C_WRITE_STROBE_POLARITY]);
            rd_a = (st_reg.flt[2] == st_reg.ctl[`C_READ_STROBE_POLARITY]);
            st_next.sact = {cs_a && wr_a, cs_a && rd_a};
            if (st_reg.sact[1] && !(cs_a && wr_a))
            begin
                st_next.ibuf[ix*8 +: 8] = st_reg.d3;
                st_next.ibf[ix] = 1'b1;
            end
            if (st_reg.sact[0] && !(cs_a && rd_a))
                st_next.obe[ix] = 1'b1;
            if ((st_reg.sact[1] && !(cs_a && wr_a)) || (st_reg.sact[0] && !(cs_a && rd_a)))
            begin
                if (st_reg.mode[`M_INCREMENT_MODE_FIELD] == 2'b11)
                    st_next.sptr = st_reg.sptr + 2'b01;
                st_next.evt = (st_reg.mode[`M_INTERRUPT_MODE_FIELD] == 2'b11) && (ix == 2'b11);
            end
        end
        st_next.pins = pins_of(st_next);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
            st_reg.ctl <= `CTL_RST;
            st_reg.mode <= `MODE_RST;
            st_reg.addr <= `ADDR_RST;
            st_reg.obe <= `OBE_RST;
        end
        else
            st_reg <= st_next;
    end

    assign hreadyout = !st_reg.rd_pend;
    assign hrdata = st_reg.hrdata;
    assign hresp = 1'b0;
    assign cpu_stall = (st_reg.phase != PH_IDLE) && (st_reg.mode[`M_INTERRUPT_MODE_FIELD] == 2'b10);
    assign port_event = st_reg.evt;
    assign port_data_out = st_reg.pins.pd_out;
    assign port_data_oe = st_reg.pins.pd_oe;
    assign port_address_out = st_reg.pins.pa_out;
    assign port_address_oe = st_reg.pins.pa_oe;
    assign chip_select_out = st_reg.pins.cs_out;
    assign chip_select_oe = st_reg.pins.cs_oe;
    assign read_strobe_out = st_reg.pins.rd_out;
    assign read_strobe_oe = st_reg.pins.rd_oe;
    assign write_strobe_out = st_reg.pins.wr_out;
    assign write_strobe_oe = st_reg.pins.wr_oe;
    assign byte_enable_pin = st_reg.pins.be_out;
    assign byte_enable_oe = st_reg.pins.be_oe;

    property p_off_quiet;
        @(posedge clk) disable iff (!arst_n)
        !st_reg.ctl[`C_EN] |-> !port_data_oe && !read_strobe_oe && !write_strobe_oe && !byte_enable_oe;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("Port drives while disabled");

    property p_idle_hold;
        @(posedge clk) disable iff (!arst_n)
        (st_reg.ctl[`C_IDL] && cpu_idle && st_reg.ctl[`C_EN] && st_reg.phase != PH_IDLE) |=>
            st_reg.phase == $past(st_reg.phase) && st_reg.cnt == $past(st_reg.cnt);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("Transfer advanced while stopped in idle");

    property p_cs_level;
        @(posedge clk) disable iff (!arst_n)
        (st_reg.ctl[`C_EN] && st_reg.mode[9] && st_reg.ctl[`C_CSF] == 2'b10) |->
            chip_select_out == (st_reg.addr[`A_CS] ~^ st_reg.ctl[`C_CSP]);
    endproperty
    a_cs_level: assert property (p_cs_level) else $error("Chip select level wrong");

    property p_latch_level;
        @(posedge clk) disable iff (!arst_n)
        (st_reg.ctl[`C_EN] && st_reg.mode[9] && st_reg.phase == PH_ALO && st_reg.ctl[`C_MUX] != 2'b00) |->
            port_address_out[0] == st_reg.ctl[`C_ALP] && port_data_out == st_reg.addr[7:0] && port_data_oe;
    endproperty
    a_latch_level: assert property (p_latch_level) else $error("Low address phase wrong");

    property p_step;
        @(posedge clk) disable iff (!arst_n)
        (xfer_end && st_reg.mode[`M_INCREMENT_MODE_FIELD] == 2'b01) |=>
            st_reg.addr[`A_STEP] == $past(st_reg.addr[`A_STEP]) + 11'h001;
    endproperty
    a_step: assert property (p_step) else $error("Address did not increment");

    property p_two_bytes;
        @(posedge clk) disable iff (!arst_n)
        xfer_end |-> (!st_reg.mode[`M_W16] || st_reg.hi);
    endproperty
    a_two_bytes: assert property (p_two_bytes) else $error("Wide transfer ended after one byte");

    property p_event;
        @(posedge clk) disable iff (!arst_n)
        (xfer_end && st_reg.mode[`M_INTERRUPT_MODE_FIELD] == 2'b01) |=> port_event ##1 !port_event;
    endproperty
    a_event: assert property (p_event) else $error("Missing end of cycle event");

    property p_zero_wait;
        @(posedge clk) disable iff (!arst_n)
        (st_reg.phase == PH_STROBE && st_reg.cnt == 4'h0 && st_reg.mode[`M_WM] == 4'h0
            && !(st_reg.ctl[`C_IDL] && cpu_idle)) |=> st_reg.phase != PH_HOLD;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("Hold entered with zero strobe wait");

endmodule

// >>> verification/ext_port_device.sv
// Purpose: Far-side parallel device answering master cycles
// Assumes: Strobes programmed active-high by the bench
// Notes: Data lines toggle every cycle when not driven
`timescale 1ns/100ps
module ext_port_device (
    input wire logic clk,
    input wire logic [7:0] port_data_out,
    input wire logic rd_on,
    input wire logic wr_on,
    input wire logic [7:0] rd_byte,
    output logic [7:0] port_data_in,
    output logic byte_valid,
    output logic [7:0] byte_val
);
    logic wr_prev = 1'b0;
    initial port_data_in = 8'h00;
    initial byte_valid = 1'b0;
    initial byte_val = 8'h00;
    always @(negedge clk)
    begin
        port_data_in <= rd_on ? rd_byte : ~port_data_in;
        byte_valid <= wr_prev && !wr_on;
        if (wr_on)
            byte_val <= port_data_out;
        wr_prev <= wr_on;
    end
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the parallel port
// Assumes: Active-high strobes; slave accesses driven from bench pins
// Notes: Read words and far-side bytes checked from queues
`timescale 1ns/100ps
`include "pmp_defines.svh"
module tb_top;
    logic clk = 1'b0, arst_n = 1'b0, hwrite = 1'b0, cpu_idle = 1'b0, rdy_seen = 1'b1, rd_dph = 1'b0;
    logic cs_in = 1'b0, wr_in = 1'b0, ext_on = 1'b0;
    logic [15:0] w;
    logic [1:0] htrans = 2'b00, pa_in = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, last_rd = 32'h0;
    logic [7:0] rd_byte = 8'h00, pd_in, pd_out, byte_val;
    logic [10:0] a;
    logic hreadyout, port_event, byte_valid, rs_out, rs_oe, ws_out, ws_oe, stall;
    int fail_count = 0, total_checks = 0, cycles = 0, events = 0, stalls = 0;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0] byte_q[$];

    parallel_master_slave_port dut (.clk(clk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(), .cpu_idle(cpu_idle), .cpu_stall(stall), .port_event(port_event),
        .port_data_in(pd_in), .port_data_out(pd_out), .port_data_oe(), .port_address_in(pa_in),
        .port_address_out(), .port_address_oe(), .chip_select_in(cs_in), .chip_select_out(),
        .chip_select_oe(), .read_strobe_in(1'b0), .read_strobe_out(rs_out), .read_strobe_oe(rs_oe),
        .write_strobe_in(wr_in), .write_strobe_out(ws_out), .write_strobe_oe(ws_oe), .byte_enable_pin(),
        .byte_enable_oe());
    ext_port_device peer (.clk(clk), .port_data_out(pd_out), .rd_on((rs_oe && rs_out) || ext_on), .rd_byte(rd_byte),
        .wr_on(ws_oe && ws_out), .port_data_in(pd_in), .byte_valid(byte_valid), .byte_val(byte_val));

    always #20 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check({24'h0, got}, {24'h0, exp});
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read results, settled at the falling edge
    always @(negedge clk)
    begin
        rdy_seen = hreadyout;
        if (stall === 1'b1)
            stalls++;
        if (rd_dph && hreadyout)
        begin
            last_rd = hrdata;
            if (msk_q[0] != 0)
                check(hrdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (hreadyout)
            rd_dph = htrans[1] && !hwrite;
        if (port_event === 1'b1)
            events++;
    end

    // Bytes seen by the far side
    always @(posedge clk)
    begin
        cycles++;
        if (byte_valid)
            check_byte(byte_val, byte_q.size() ? byte_q.pop_front() : ~byte_val);
        if (cycles == 20000)
        begin
            fail_count++;
            stop_test;
        end
    end

    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk);
        haddr <= {24'h0, ad};
        htrans <= 2'b10;
        hwrite <= wr;
        if (!wr)
        begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        do @(posedge clk); while (rdy_seen !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (rdy_seen !== 1'b1);
    endtask

    task automatic wait_idle;
        do ahb(1'b0, `OFF_MODE, 32'h0, 32'h0); while (last_rd[15] !== 1'b0);
    endtask

    task automatic wr_b(input logic [7:0] b);
        byte_q.push_back(b);
        ahb(1'b1, `OFF_DATA, {24'h0, b}, 32'h0);
        wait_idle;
    endtask

    initial
    begin
        void'($urandom(75410));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        pa_in <= 2'($urandom);
        ahb(1'b0, `OFF_CTL, 32'h0, 32'hffff);
        ahb(1'b0, `OFF_MODE, 32'h0, 32'hffff);
        ahb(1'b0, `OFF_ADDR, 32'h0, 32'hffff);
        ahb(1'b1, `OFF_CTL, 32'hffff, 32'h0);
        ahb(1'b0, `OFF_CTL, 32'hbfef, 32'hffff);
        ahb(1'b1, 8'hfc, 32'h1234, 32'h0);
        ahb(1'b0, 8'hfc, 32'h0, 32'hffffffff);
        ahb(1'b1, `OFF_CTL, 32'h0, 32'h0);
        ahb(1'b1, `OFF_MODE, 32'h2a10, 32'h0);
        ahb(1'b1, `OFF_DATA, 32'h5a, 32'h0);
        ahb(1'b0, `OFF_MODE, 32'h2a10, 32'hffff);
        a = 11'($urandom) & 11'h7f8;
        ahb(1'b1, `OFF_ADDR, {21'h0, a}, 32'h0);
        ahb(1'b1, `OFF_CTL, 32'h8303, 32'h0);
        for (int i = 0; i < 3; i++)
            wr_b(8'($urandom));
        ahb(1'b0, `OFF_ADDR, {21'h0, a + 11'd3}, 32'h7ff);
        rd_byte <= 8'($urandom);
        ahb(1'b0, `OFF_DATA, 32'h0, 32'h0);
        wait_idle;
        ahb(1'b0, `OFF_DATA, {24'h0, rd_byte}, 32'hff);
        wait_idle;
        ahb(1'b1, `OFF_MODE, 32'h3210, 32'h0);
        wr_b(8'($urandom));
        ahb(1'b0, `OFF_ADDR, {21'h0, a + 11'd4}, 32'h7ff);
        ahb(1'b1, `OFF_CTL, 32'ha303, 32'h0);
        cpu_idle <= 1'b1;
        ahb(1'b1, `OFF_DATA, 32'h3c, 32'h0);
        repeat (20) @(posedge clk);
        ahb(1'b0, `OFF_MODE, 32'h3210, 32'hffff);
        cpu_idle <= 1'b0;
        byte_q.push_back(8'hc3);
        ahb(1'b1, `OFF_DATA, 32'hc3, 32'h0);
        cpu_idle <= 1'b1;
        repeat (20) @(posedge clk);
        ahb(1'b0, `OFF_MODE, 32'hb210, 32'hffff);
        cpu_idle <= 1'b0;
        wait_idle;
        ahb(1'b0, `OFF_ADDR, {21'h0, a + 11'd3}, 32'h7ff);
        // Wide write, low address multiplexed, stall mode
        ahb(1'b1, `OFF_MODE, 32'h4604, 32'h0);
        ahb(1'b1, `OFF_CTL, 32'h8b03, 32'h0);
        w = 16'($urandom);
        byte_q.push_back(w[7:0]);
        byte_q.push_back(w[15:8]);
        ahb(1'b1, `OFF_DATA, {16'h0, w}, 32'h0);
        wait_idle;
        // Legacy slave write from the far side
        ahb(1'b1, `OFF_CTL, 32'h830b, 32'h0);
        ahb(1'b1, `OFF_MODE, 32'h0, 32'h0);
        ext_on <= 1'b1;
        cs_in <= 1'b1;
        wr_in <= 1'b1;
        repeat (8) @(posedge clk);
        cs_in <= 1'b0;
        wr_in <= 1'b0;
        repeat (8) @(posedge clk);
        ext_on <= 1'b0;
        ahb(1'b0, `OFF_STAT, 32'h10f, 32'hfff);
        ahb(1'b0, `OFF_IBUF, {24'h0, rd_byte}, 32'hff);
        ahb(1'b0, `OFF_STAT, 32'h00f, 32'hfff);
        repeat (20) @(posedge clk);
        check(events, 32'd7);
        // Address 1, then setup 1, strobe 2, hold 1 per byte
        check(stalls, 32'd9);
        stop_test;
    end
endmodule
